// file: bench/owfp_master.sv
/*
  Two-wire master and fuse array stand-in.
  Assumes a pulled-up data wire and fuses that keep their state across reset.
*/
`timescale 1ns/1ps
module owfp_master (
  input wire logic                  clk,
  input wire logic                  sda_out,
  input wire logic                  sda_oe,
  input wire owfp_pkg::owfp_blow_t  fuse_blow,
  output logic                      scl,
  output logic                      sda,
  output owfp_pkg::owfp_sense_t     fuse_sense
);
  import owfp_pkg::*;
  logic       sda_m = 1'b1;
  logic       test_bad = 1'b0;
  logic [5:0] stuck = 6'h0;
  initial scl = 1'b1;
  // Pulled-up wire, low while either side pulls
  assign sda = sda_m & ~(sda_oe & ~sda_out);
  // Fuses keep a blow; failing ones never take it
  always @(posedge clk) begin
    if (fuse_blow.test) fuse_sense.test_ok <= !test_bad;
    fuse_sense.data <= fuse_sense.data | (fuse_blow.data & ~stuck);
    if (fuse_blow.lock) fuse_sense.lock <= 1'b1;
  end
  task automatic new_unit(input logic tb, input logic [5:0] st);
    fuse_sense = '0;
    test_bad = tb;
    stuck = st;
  endtask : new_unit
  // Nine clock pulses, sampling mid-high
  task automatic bits(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      sda_m = d[i];
      #31 scl = 1'b1;
      #31 q[i] = sda;
      #31 scl = 1'b0;
      #32;
    end
  endtask : bits
  task automatic start;
    sda_m = 1'b1;
    scl = 1'b1;
    #60 sda_m = 1'b0;
    #60 scl = 1'b0;
    #30;
  endtask : start
  task automatic stop;
    sda_m = 1'b0;
    #30 scl = 1'b1;
    #30 sda_m = 1'b1;
    #60;
  endtask : stop
  task automatic write_frame(input logic [6:0] adr, input logic t, input logic [5:0] c, output logic [2:0] nk);
    logic [8:0] q;
    start();
    bits({adr, 1'b0, 1'b1}, q);
    nk[2] = q[0];
    bits({t, 7'h0, 1'b1}, q);
    nk[1] = q[0];
    bits({2'h0, c, 1'b1}, q);
    nk[0] = q[0];
    stop();
  endtask : write_frame
  task automatic read_frame(input logic [6:0] adr, output logic [7:0] v, output logic nk);
    logic [8:0] q;
    start();
    bits({adr, 1'b1, 1'b1}, q);
    nk = q[0];
    bits(9'h1ff, q);
    v = q[8:1];
    stop();
  endtask : read_frame
endmodule : owfp_master

// file: bench/owfp_monitor.sv
/*
  Port checker for the fuse programmer top.
  Assumes it is bound into owfp_top with the same sequencing divide.
*/
`timescale 1ns/1ps
module owfp_monitor #(
  parameter int SEQ_DIV_P = owfp_pkg::SEQ_DIV
) (
  input wire logic                  clk,
  input wire logic                  reset,
  input wire owfp_pkg::owfp_sense_t fuse_sense,
  input wire owfp_pkg::owfp_blow_t  fuse_blow,
  input wire logic                  seq_clk_en,
  input wire logic [5:0]            wiper_code,
  input wire logic [5:0]            top_distance,
  input wire logic [63:0]           tap_select,
  input wire logic                  validation_status_high,
  input wire logic                  validation_status_low,
  input wire logic [3:0]            reg_addr,
  input wire logic                  reg_read,
  input wire logic [31:0]           reg_rdata
);
  import owfp_pkg::*;
  localparam int LO = 8 * SEQ_DIV_P;
  localparam int HI = 10 * SEQ_DIV_P;
  logic [2:0]  boot;
  logic [15:0] seq_cnt;
  wire  [1:0]  vs = {validation_status_high, validation_status_low};
  // Edges since reset release, saturating
  always_ff @(posedge clk or posedge reset) begin
    if (reset) boot <= 3'h0;
    else if (boot != 3'h7) boot <= boot + 3'h1;
  end
  // Edges the sequencer has been running
  always_ff @(posedge clk or posedge reset) begin
    if (reset) seq_cnt <= 16'h0;
    else seq_cnt <= seq_clk_en ? seq_cnt + 16'h1 : 16'h0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_tap; !$past(reset) |-> tap_select == (64'h1 << $past(wiper_code)); endproperty
  a_tap: assert property (p_tap) else $error("tap select wrong");
  property p_dist; !$past(reset) |-> top_distance == 6'h3f - $past(wiper_code); endproperty
  a_dist: assert property (p_dist) else $error("top distance wrong");
  property p_vs_hold; boot == 3'h7 && !seq_clk_en && !$past(seq_clk_en) |-> $stable(vs); endproperty
  a_vs_hold: assert property (p_vs_hold) else $error("status moved while idle");
  property p_lock_hold; boot == 3'h7 && vs == VS_LOCKED |=> $stable(wiper_code); endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("locked wiper moved");
  property p_blow_en; fuse_blow != 8'h0 |-> seq_clk_en && $onehot(fuse_blow); endproperty
  a_blow_en: assert property (p_blow_en) else $error("blow outside sequence");
  property p_seq_start; $rose(seq_clk_en) |-> fuse_blow.test && fuse_blow.data == 6'h0; endproperty
  a_seq_start: assert property (p_seq_start) else $error("sequence not opened by test blow");
  property p_data_after_test; $rose(|fuse_blow.data) |-> fuse_sense.test_ok; endproperty
  a_data_after_test: assert property (p_data_after_test) else $error("data blow after bad test");
  property p_lock_lag; $rose(fuse_blow.lock) |-> seq_cnt inside {[LO:HI]}; endproperty
  a_lock_lag: assert property (p_lock_lag) else $error("lock blow at wrong time");
  property p_lock_match; $rose(fuse_blow.lock) |-> fuse_sense.data == wiper_code; endproperty
  a_lock_match: assert property (p_lock_match) else $error("lock blown on mismatch");
  property p_read;
    $past(reg_read) && $past(reg_addr) == REG_STATE |-> reg_rdata[7:0] == {$past(vs), $past(wiper_code)};
  endproperty
  a_read: assert property (p_read) else $error("state read wrong");
  property p_boot_mid; boot == 3'h6 && !fuse_sense.lock |-> wiper_code == CODE_MID && vs == VS_READY; endproperty
  a_boot_mid: assert property (p_boot_mid) else $error("no midscale at power-on");
  property p_boot_fused; boot == 3'h6 && fuse_sense.lock |-> wiper_code == fuse_sense.data && vs == VS_LOCKED;
  endproperty
  a_boot_fused: assert property (p_boot_fused) else $error("fused code not loaded");
  c_locked: cover property (vs == VS_LOCKED);
  c_test_fail: cover property (vs == VS_TEST_FAIL);
  c_mismatch: cover property (vs == VS_MISMATCH);
endmodule : owfp_monitor

bind owfp_top owfp_monitor #(.SEQ_DIV_P(SEQ_DIV_P)) u_mon (.clk(clk), .reset(reset), .fuse_sense(fuse_sense),
  .fuse_blow(fuse_blow), .seq_clk_en(seq_clk_en), .wiper_code(wiper_code), .top_distance(top_distance),
  .tap_select(tap_select), .validation_status_high(validation_status_high),
  .validation_status_low(validation_status_low), .reg_addr(reg_addr), .reg_read(reg_read), .reg_rdata(reg_rdata));

// file: bench/owfp_top_test.sv
/*
  Self-checking bench for the fuse programmer top.
  Assumes the partner model drives the serial pins and stands in for the fuses.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fails++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module owfp_top_test;
  import owfp_pkg::*;
  logic        clk = 0, reset = 1, pin = 0, reg_write = 0, reg_read = 0, scl, sda, sda_out, sda_oe, seq_en;
  logic        vs_hi, vs_lo, irq, nr;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, r;
  logic [5:0]  wiper_code, top_distance;
  logic [63:0] tap_select;
  logic [2:0]  nk;
  logic [7:0]  rb;
  owfp_sense_t fuse_sense;
  owfp_blow_t  fuse_blow;
  int          fails = 0, check_count = 0, seed = 32'h77d9, m_wiper, m_vs, code, n, ev;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  owfp_top #(.SEQ_DIV_P(8)) u_dut (.clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .address_select_pin(pin), .fuse_sense(fuse_sense), .fuse_blow(fuse_blow), .seq_clk_en(seq_en),
    .wiper_code(wiper_code), .top_distance(top_distance), .tap_select(tap_select), .validation_status_high(vs_hi),
    .validation_status_low(vs_lo), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq));
  owfp_master u_part (.clk(clk), .sda_out(sda_out), .sda_oe(sda_oe), .fuse_blow(fuse_blow), .scl(scl), .sda(sda),
    .fuse_sense(fuse_sense));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  task automatic power_up;
    reset <= 1'b1;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (12) @(posedge clk);
  endtask : power_up
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_rd
  task automatic check_state;
    u_part.read_frame({DEV_ADDR, pin}, rb, nr);
    `CHK("wiper", m_wiper, wiper_code)
    `CHK("tap", 64'h1 << m_wiper, tap_select)
    `CHK("top distance", 63 - m_wiper, top_distance)
    `CHK("status", m_vs, ({vs_hi, vs_lo}))
    `CHK("read byte", ({m_vs[1:0], m_wiper[5:0]}), rb)
    `CHK("read ack", 0, nr)
    reg_rd(REG_STATE, r);
    `CHK("state reg", ({m_vs[1:0], m_wiper[5:0]}), r[7:0])
  endtask : check_state
  // one program attempt on each fresh unit; a locked unit also gets a refused second attempt
  task automatic prog(input int bad);
    code = ($random(seed) & 63) | 1;
    u_part.new_unit(bad == 1, bad == 2 ? code[5:0] : 6'h0);
    power_up();
    m_wiper = 32;
    m_vs = 0;
    check_state();
    u_part.write_frame({DEV_ADDR, pin}, 1'b1, code[5:0], nk);
    `CHK("program acks", 0, nk)
    n = 0;
    while (seq_en !== 1'b0 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    if (n == 5000) begin
      fails++;
      give_verdict();
    end
    m_wiper = code;
    m_vs = bad == 1 ? VS_TEST_FAIL : bad == 2 ? VS_MISMATCH : VS_LOCKED;
    ev = bad == 1 ? EV_TEST_FAIL : bad == 2 ? EV_MISMATCH : EV_DONE;
    check_state();
    `CHK("data fuses", bad == 0 ? code : 0, fuse_sense.data)
    reg_rd(REG_IRQ_STATUS, r);
    `CHK("events", (1 << EV_WRITE) | (1 << ev), r)
    `CHK("irq masked", 0, irq)
    reg_wr(REG_IRQ_MASK, 32'h1 << ev);
    `CHK("irq raised", 1, irq)
    reg_wr(REG_IRQ_STATUS, 32'hf);
    `CHK("irq cleared", 0, irq)
    if (bad == 0) begin
      u_part.write_frame({DEV_ADDR, pin}, 1'b0, code[5:0] ^ 6'h15, nk);
      check_state();
      power_up();
      check_state();
      u_part.write_frame({DEV_ADDR, pin}, 1'b1, code[5:0] ^ 6'h2a, nk);
      `CHK("no restart", 0, seq_en)
      check_state();
    end
    $display("test program %0d done", bad);
  endtask : prog
  // Main sequence
  initial begin
    pin <= 1'($random(seed));
    u_part.new_unit(1'b0, 6'h0);
    power_up();
    m_wiper = 32;
    m_vs = 0;
    check_state();
    reg_rd(REG_IRQ_MASK, r);
    `CHK("mask reset", 0, r)
    reg_wr(4'hc, 32'hf);
    reg_rd(4'hc, r);
    `CHK("unmapped", 0, r)
    u_part.write_frame({DEV_ADDR, ~pin}, 1'b0, 6'h05, nk);
    `CHK("foreign acks", 7, nk)
    check_state();
    for (int i = 0; i < 6; i++) begin
      code = i == 0 ? 0 : i == 1 ? 63 : $random(seed) & 63;
      u_part.write_frame({DEV_ADDR, pin}, 1'b0, code[5:0], nk);
      `CHK("write acks", 0, nk)
      m_wiper = code;
      check_state();
    end
    $display("test adjust done");
    for (int b = 0; b < 3; b++) prog(b);
    give_verdict();
  end
endmodule : owfp_top_test

// file: core/owfp_pkg.sv
/*
  Package for the one-time fuse programmer of a 64-tap resistor wiper.
  Holds timing counts, status codes, register offsets and the fuse carriers.
  Assumes a 200 MHz system clock.
*/
package owfp_pkg;

  // Clock and internal sequencing clock
  localparam int CLK_PERIOD_NS     = 5;
  localparam int SEQ_PERIOD_NS     = 1000;
  localparam int SEQ_DIV           = (SEQ_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BOOT_CYCLES       = 4;

  // Wiper code and serial device address
  localparam int          CODE_W   = 6;
  localparam int          TAPS     = 64;
  localparam logic [5:0]  CODE_MID = 6'h20;
  localparam logic [5:0]  DEV_ADDR = 6'h16;

  // Validation status codes
  localparam logic [1:0]  VS_READY     = 2'h0;
  localparam logic [1:0]  VS_TEST_FAIL = 2'h1;
  localparam logic [1:0]  VS_MISMATCH  = 2'h2;
  localparam logic [1:0]  VS_LOCKED    = 2'h3;

  // Register port offsets and fields
  localparam logic [3:0]  REG_IRQ_STATUS = 4'h0;
  localparam logic [3:0]  REG_IRQ_MASK   = 4'h4;
  localparam logic [3:0]  REG_STATE      = 4'h8;
  localparam int          EV_W           = 4;
  localparam int          EV_WRITE       = 0;
  localparam int          EV_DONE        = 1;
  localparam int          EV_TEST_FAIL   = 2;
  localparam int          EV_MISMATCH    = 3;
  localparam logic [3:0]  IRQ_RESET      = 4'h0;

  // Fuse blow strobes toward the fuse array
  typedef struct packed {
    logic       test;
    logic [5:0] data;
    logic       lock;
  } owfp_blow_t;

  // Fuse sense levels from the fuse array
  typedef struct packed {
    logic       test_ok;
    logic [5:0] data;
    logic       lock;
  } owfp_sense_t;

  typedef enum logic [2:0] {
    S_BOOT     = 3'b000,
    S_IDLE     = 3'b001,
    S_TEST     = 3'b010,
    S_TEST_CHK = 3'b011,
    S_DATA     = 3'b100,
    S_CMP      = 3'b101,
    S_LOCK     = 3'b110,
    S_HALT     = 3'b111
  } owfp_seq_t;

endpackage : owfp_pkg

// file: core/owfp_top.sv
/*
  One-time fuse programmer with two-wire serial slave, wiper register,
  tap decoder, fuse sequencer and an interrupt register port.
  Assumes serial pins and fuse sense levels are asynchronous to clk; power-on
  is signalled by reset; the fuse array answers its blow strobes within one
  internal sequencing clock period.
*/
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps

module owfp_top #(
  parameter int SEQ_DIV_P = owfp_pkg::SEQ_DIV
) (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic                 scl_in,
  input  wire logic                 sda_in,
  output logic                      sda_out,
  output logic                      sda_oe,
  input  wire logic                 address_select_pin,
  input  wire owfp_pkg::owfp_sense_t fuse_sense,
  output owfp_pkg::owfp_blow_t      fuse_blow,
  output logic                      seq_clk_en,
  output logic [5:0]                wiper_code,
  output logic [5:0]                top_distance,
  output logic [63:0]               tap_select,
  output logic                      validation_status_high,
  output logic                      validation_status_low,
  input  wire logic [3:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_write,
  input  wire logic                 reg_read,
  output logic [31:0]               reg_rdata,
  output logic                      irq
);
  import owfp_pkg::*;

  logic [1:0]   scl_sync;
  logic [1:0]   sda_sync;
  logic [1:0]   pin_sync;
  owfp_sense_t  sense_meta;
  owfp_sense_t  sense_s;
  logic         scl_d;
  logic         sda_d;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_cond;
  logic         stop_cond;
  logic         active;
  logic         selected;
  logic         rw;
  logic [3:0]   bit_cnt;
  logic [1:0]   byte_idx;
  logic [7:0]   shreg;
  logic [7:0]   tx;
  logic [7:0]   instr;
  logic         wr_pulse;
  logic [5:0]   wr_code;
  logic         program_sequence_trigger;
  logic         write_ok;
  owfp_seq_t    state;
  logic [1:0]   vstatus;
  logic [15:0]  tick_cnt;
  logic         tick;
  logic [2:0]   boot_cnt;
  logic         boot_load;
  logic [2:0]   fuse_idx;
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] irq_status;
  logic [EV_W-1:0] irq_mask;
  logic [EV_W-1:0] clr_bits;

  // Two-flop synchronisers for every asynchronous input
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      scl_sync   <= 2'h3;
      sda_sync   <= 2'h3;
      pin_sync   <= 2'h0;
      sense_meta <= '0;
      sense_s    <= '0;
    end else begin
      scl_sync   <= {scl_sync[0], scl_in};
      sda_sync   <= {sda_sync[0], sda_in};
      pin_sync   <= {pin_sync[0], address_select_pin};
      sense_meta <= fuse_sense;
      sense_s    <= sense_meta;
    end
  end

  // Delayed copies of the synchronised bus for edge detection
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_sync[1];
      sda_d <= sda_sync[1];
    end
  end

  assign scl_rise   = scl_sync[1] & ~scl_d;
  assign scl_fall   = ~scl_sync[1] & scl_d;
  assign start_cond = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
  assign stop_cond  = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];
  assign sda_out    = 1'b0;   // Open drain: only ever pulls low

  // Serial slave: bit counting, acknowledge and readback drive
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      active   <= 1'b0;
      selected <= 1'b0;
      rw       <= 1'b0;
      bit_cnt  <= 4'h0;
      byte_idx <= 2'h0;
      shreg    <= 8'h00;
      tx       <= 8'h00;
      instr    <= 8'h00;
      sda_oe   <= 1'b0;
      wr_pulse <= 1'b0;
      wr_code  <= 6'h00;
    end else begin
      wr_pulse <= 1'b0;
      if (start_cond) begin
        active   <= 1'b1;
        selected <= 1'b0;
        bit_cnt  <= 4'h0;
        byte_idx <= 2'h0;
        sda_oe   <= 1'b0;
      end else if (stop_cond) begin
        active <= 1'b0;
        sda_oe <= 1'b0;
      end else if (active && scl_rise) begin
        if (bit_cnt < 4'h8) begin
          shreg <= {shreg[6:0], sda_sync[1]};
        end
        if (bit_cnt != 4'h9) begin
          bit_cnt <= bit_cnt + 4'h1;
        end
      end else if (active && scl_fall) begin
        if (bit_cnt == 4'h8) begin
          if (byte_idx == 2'h0) begin
            if (shreg[7:1] == {DEV_ADDR, pin_sync[1]}) begin
              selected <= 1'b1;
              rw       <= shreg[0];
              sda_oe   <= 1'b1;
            end else begin
              active <= 1'b0;
            end
          end else if (selected && !rw && byte_idx == 2'h1) begin
            instr  <= shreg;
            sda_oe <= 1'b1;
          end else if (selected && !rw && byte_idx == 2'h2) begin
            wr_code  <= shreg[5:0];
            wr_pulse <= 1'b1;
            sda_oe   <= 1'b1;
          end else begin
            sda_oe <= 1'b0;
          end
        end else if (bit_cnt == 4'h9) begin
          bit_cnt <= 4'h0;
          if (byte_idx != 2'h3) begin
            byte_idx <= byte_idx + 2'h1;
          end
          if (rw && byte_idx == 2'h0) begin
            tx     <= {vstatus, wiper_code};
            sda_oe <= ~vstatus[1];
          end else begin
            sda_oe <= 1'b0;
          end
        end else if (rw && byte_idx == 2'h1) begin
          tx     <= {tx[6:0], 1'b0};
          sda_oe <= ~tx[6];
        end
      end
    end
  end

  // writes refused once locked or busy
  assign write_ok                 = wr_pulse && state == S_IDLE && vstatus != VS_LOCKED;
  // single attempt: only from ready status
  assign program_sequence_trigger = write_ok && instr[7] && vstatus == VS_READY;
  assign boot_load                = state == S_BOOT && boot_cnt == 3'(BOOT_CYCLES - 1);

  // Internal sequencing clock, running only while programming
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tick_cnt <= 16'h0000;
    end else if (!seq_clk_en || tick) begin
      tick_cnt <= 16'h0000;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
    end
  end

  assign tick       = seq_clk_en && tick_cnt == 16'(SEQ_DIV_P - 1);
  assign seq_clk_en = state == S_TEST || state == S_TEST_CHK || state == S_DATA ||
                      state == S_CMP || state == S_LOCK;

  // Fuse sequencer and validation status
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state     <= S_BOOT;
      vstatus   <= VS_READY;
      boot_cnt  <= 3'h0;
      fuse_idx  <= 3'h0;
      fuse_blow <= '0;
    end else begin
      case (state)
        S_BOOT: begin
          boot_cnt <= boot_cnt + 3'h1;
          if (boot_load) begin
            vstatus <= sense_s.lock ? VS_LOCKED : VS_READY;
            state   <= S_IDLE;
          end
        end
        S_IDLE: begin
          if (program_sequence_trigger) begin
            fuse_blow.test <= 1'b1;
            state          <= S_TEST;
          end
        end
        S_TEST: begin
          if (tick) begin
            fuse_blow.test <= 1'b0;
            state          <= S_TEST_CHK;
          end
        end
        S_TEST_CHK: begin
          if (tick) begin
            if (sense_s.test_ok) begin
              fuse_idx       <= 3'h0;
              fuse_blow.data <= wiper_code & 6'h01;
              state          <= S_DATA;
            end else begin
              vstatus <= VS_TEST_FAIL;
              state   <= S_HALT;
            end
          end
        end
        S_DATA: begin
          // one data fuse per internal cycle
          if (tick) begin
            if (fuse_idx == 3'(CODE_W - 1)) begin
              fuse_blow.data <= 6'h00;
              state          <= S_CMP;
            end else begin
              fuse_idx       <= fuse_idx + 3'h1;
              fuse_blow.data <= wiper_code & (6'h01 << (fuse_idx + 3'h1));
            end
          end
        end
        S_CMP: begin
          if (tick) begin
            if (sense_s.data == wiper_code) begin
              fuse_blow.lock <= 1'b1;
              state          <= S_LOCK;
            end else begin
              vstatus <= VS_MISMATCH;
              state   <= S_HALT;
            end
          end
        end
        S_LOCK: begin
          if (tick) begin
            fuse_blow.lock <= 1'b0;
            vstatus        <= VS_LOCKED;
            state          <= S_HALT;
          end
        end
        default: begin
          state <= S_HALT;
        end
      endcase
    end
  end

  assign validation_status_high = vstatus[1];
  assign validation_status_low  = vstatus[0];

  // Wiper register: power-on preset or fused code, then serial writes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wiper_code <= CODE_MID;
    end else if (boot_load) begin
      wiper_code <= sense_s.lock ? sense_s.data : CODE_MID;
    end else if (write_ok) begin
      wiper_code <= wr_code;
    end
  end

  // Tap decoder for the variable_resistor_array
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tap_select   <= 64'h0;
      top_distance <= 6'h00;
    end else begin
      // code zero is the bottom tap
      tap_select   <= 64'h1 << wiper_code;
      // taps above wiper shrink as code grows
      top_distance <= 6'h3f - wiper_code;
    end
  end

  // Interrupt events, sticky status with set winning over clear
  assign events[EV_WRITE]     = write_ok;
  assign events[EV_DONE]      = state == S_LOCK && tick;
  assign events[EV_TEST_FAIL] = state == S_TEST_CHK && tick && !sense_s.test_ok;
  assign events[EV_MISMATCH]  = state == S_CMP && tick && sense_s.data != wiper_code;
  assign clr_bits = (reg_write && reg_addr == REG_IRQ_STATUS) ? reg_wdata[EV_W-1:0] : '0;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_status <= IRQ_RESET;
      irq_mask   <= IRQ_RESET;
    end else begin
      irq_status <= (irq_status & ~clr_bits) | events;
      if (reg_write && reg_addr == REG_IRQ_MASK) begin
        irq_mask <= reg_wdata[EV_W-1:0];
      end
    end
  end

  assign irq = |(irq_status & irq_mask);

  // Register read port, data valid for one cycle after the strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 32'h0;
    end else if (reg_read) begin
      if (reg_addr == REG_IRQ_STATUS) begin
        reg_rdata <= {28'h0, irq_status};
      end else if (reg_addr == REG_IRQ_MASK) begin
        reg_rdata <= {28'h0, irq_mask};
      end else if (reg_addr == REG_STATE) begin
        reg_rdata <= {21'h0, state, vstatus, wiper_code};
      end else begin
        reg_rdata <= 32'h0;
      end
    end else begin
      reg_rdata <= 32'h0;
    end
  end

endmodule : owfp_top
